// ===== logic/cell_chain_pkg.sv
package cell_chain_pkg;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_ARITH,
    MODE_COUNTER
  } cell_mode_t;

  localparam int CELLS_PER_CLUSTER = 10;
  localparam int CLUSTERS = 3;
  localparam int ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_LUT = 8'h04;
  localparam logic [7:0] OFF_OP1 = 8'h08;
  localparam logic [7:0] OFF_OP2 = 8'h0C;
  localparam logic [7:0] OFF_OP3 = 8'h10;
  localparam logic [7:0] OFF_OP4 = 8'h14;
  localparam logic [7:0] OFF_LOADVAL = 8'h18;
  localparam logic [7:0] OFF_CMD = 8'h1C;
  localparam logic [7:0] OFF_OUTA = 8'h20;
  localparam logic [7:0] OFF_OUTB = 8'h24;
  localparam logic [7:0] OFF_STATUS = 8'h28;
  localparam logic [7:0] OFF_REGQ = 8'h2C;

  // control and command field positions
  localparam int CTRL_MODE_LO = 0;
  localparam int CTRL_CAS_OR = 2;
  localparam int CTRL_IN3_CARRY = 3;
  localparam int CTRL_OUTA_REG = 4;
  localparam int CTRL_OUTB_REG = 5;
  localparam int CTRL_CELL_CE = 6;
  localparam int CTRL_CARRY_SEED = 7;
  localparam int CMD_LOAD_LO = 8;

  // reset values: normal mode, cell clock enabled, out_b from register
  localparam logic [7:0] CTRL_RST = 8'h60;
  localparam logic [15:0] LUT_RST = 16'hE896;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== logic/logic_cell_carry_cascade.sv
`timescale 1ns/1ps
module logic_cell_carry_cascade #(
  parameter int CELLS_PER_CLUSTER = cell_chain_pkg::CELLS_PER_CLUSTER,
  parameter int CLUSTERS = cell_chain_pkg::CLUSTERS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int NCELL = CELLS_PER_CLUSTER * CLUSTERS;

  ////////////////////////////////////////////////////////////////////////////
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl_r;
  logic [15:0] lut_r;
  logic [NCELL-1:0] op1_r, op2_r, op3_r, op4_r, loadval_r;
  logic [CLUSTERS-1:0] clr_r, load_r;
  logic [NCELL-1:0] q_r, q_nxt;
  logic [NCELL-1:0] f_w, out_a_w, out_b_w;
  logic [NCELL:0] cy_w, cs_w;
  cell_chain_pkg::cell_mode_t mode;
  logic cas_or, cell_ce;

  assign mode = cell_chain_pkg::cell_mode_t'(ctrl_r[cell_chain_pkg::CTRL_MODE_LO +: 2]);
  assign cas_or = ctrl_r[cell_chain_pkg::CTRL_CAS_OR];
  assign cell_ce = ctrl_r[cell_chain_pkg::CTRL_CELL_CE];

  // chain position to cluster: even clusters first, then odd ones
  function automatic int phys_cluster(input int k);
    int n_even;
    n_even = (CLUSTERS + 1) / 2;
    return (k < n_even) ? 2 * k : 2 * (k - n_even) + 1;
  endfunction

  // counter seed is the count chain start; identity of the cascade op
  assign cy_w[0] = ctrl_r[cell_chain_pkg::CTRL_CARRY_SEED];
  assign cs_w[0] = ~cas_or;

  ////////////////////////////////////////////////////////////////////////////
  genvar p;
  generate
    for (p = 0; p < NCELL; p++) begin : g_cell
      localparam int CL = phys_cluster(p / CELLS_PER_CLUSTER);
      logic cin, in3, up, cnt_en;
      logic [3:0] idx4;
      logic [2:0] idx3;
      // only ripple link; crossing into the next same-parity cluster
      // is the same wire, so chain length costs no routing
      assign cin = cy_w[p];
      assign in3 = ctrl_r[cell_chain_pkg::CTRL_IN3_CARRY] ? cin : op3_r[p];
      assign idx4 = {op4_r[p], in3, op2_r[p], op1_r[p]};
      assign idx3 = {cin, op2_r[p], op1_r[p]};
      assign up = op2_r[p];
      assign cnt_en = op1_r[p];

      always_comb begin
        case (mode)
          cell_chain_pkg::MODE_ARITH: begin
            // top cell only brings the final carry out to routing
            f_w[p] = (p == NCELL - 1) ? cin : lut_r[{1'b0, idx3}];
            cy_w[p+1] = lut_r[{1'b1, idx3}];
          end
          cell_chain_pkg::MODE_COUNTER: begin
            f_w[p] = q_r[p] ^ cin;
            cy_w[p+1] = up ? (q_r[p] & cin) : (~q_r[p] & cin);
          end
          default: begin
            f_w[p] = lut_r[idx4];
            cy_w[p+1] = cin;
          end
        endcase
      end

      // or through inverted and: same gate, no extra stage per cell
      assign cs_w[p+1] = cas_or ? (f_w[p] | cs_w[p]) : (f_w[p] & cs_w[p]);

      always_comb begin
        q_nxt[p] = q_r[p];
        if (cell_ce) begin
          if (clr_r[CL]) begin
            q_nxt[p] = 1'b0;
          end else if (load_r[CL]) begin
            q_nxt[p] = loadval_r[p];
          end else if (mode == cell_chain_pkg::MODE_COUNTER) begin
            q_nxt[p] = cnt_en ? f_w[p] : q_r[p];
          end else if (mode == cell_chain_pkg::MODE_ARITH) begin
            q_nxt[p] = f_w[p];
          end else begin
            q_nxt[p] = op4_r[p];
          end
        end
      end

      assign out_a_w[p] = ctrl_r[cell_chain_pkg::CTRL_OUTA_REG] ? q_r[p] : f_w[p];
      assign out_b_w[p] = ctrl_r[cell_chain_pkg::CTRL_OUTB_REG] ? q_r[p] : f_w[p];
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= '0;
    end else if (ce) begin
      q_r <= q_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic aw_have_r, w_have_r, bvalid_r, rvalid_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic aw_hs, w_hs, ar_hs, do_wr;
  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;

  assign s_axi_awready = ce && !aw_have_r && !bvalid_r;
  assign s_axi_wready = ce && !w_have_r && !bvalid_r;
  assign s_axi_arready = ce && !rvalid_r;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign do_wr = (aw_have_r || aw_hs) && (w_have_r || w_hs);
  assign wa = aw_have_r ? awaddr_r : s_axi_awaddr;
  assign wd = w_have_r ? wdata_r : s_axi_wdata;
  assign ws = w_have_r ? wstrb_r : s_axi_wstrb;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (ce) begin
      aw_have_r <= do_wr ? 1'b0 : (aw_have_r || aw_hs);
      w_have_r <= do_wr ? 1'b0 : (w_have_r || w_hs);
      if (aw_hs) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  logic wa_ok;
  assign wa_ok = (wa <= cell_chain_pkg::OFF_CMD) && (wa[1:0] == 2'b00);

  // write side; command bits are one-cycle pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= cell_chain_pkg::CTRL_RST;
      lut_r <= cell_chain_pkg::LUT_RST;
      op1_r <= '0;
      op2_r <= '0;
      op3_r <= '0;
      op4_r <= '0;
      loadval_r <= '0;
      clr_r <= '0;
      load_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= cell_chain_pkg::RESP_OKAY;
    end else if (ce) begin
      clr_r <= '0;
      load_r <= '0;
      if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (do_wr) begin
        bvalid_r <= 1'b1;
        bresp_r <= wa_ok ? cell_chain_pkg::RESP_OKAY : cell_chain_pkg::RESP_SLVERR;
        if (wa == cell_chain_pkg::OFF_CTRL) begin
          ctrl_r <= 8'(merge({24'h000000, ctrl_r}, wd, ws));
        end else if (wa == cell_chain_pkg::OFF_LUT) begin
          lut_r <= 16'(merge({16'h0000, lut_r}, wd, ws));
        end else if (wa == cell_chain_pkg::OFF_OP1) begin
          op1_r <= NCELL'(merge(32'(op1_r), wd, ws));
        end else if (wa == cell_chain_pkg::OFF_OP2) begin
          op2_r <= NCELL'(merge(32'(op2_r), wd, ws));
        end else if (wa == cell_chain_pkg::OFF_OP3) begin
          op3_r <= NCELL'(merge(32'(op3_r), wd, ws));
        end else if (wa == cell_chain_pkg::OFF_OP4) begin
          op4_r <= NCELL'(merge(32'(op4_r), wd, ws));
        end else if (wa == cell_chain_pkg::OFF_LOADVAL) begin
          loadval_r <= NCELL'(merge(32'(loadval_r), wd, ws));
        end else if (wa == cell_chain_pkg::OFF_CMD) begin
          clr_r <= ws[0] ? wd[CLUSTERS-1:0] : '0;
          load_r <= ws[1] ? wd[cell_chain_pkg::CMD_LOAD_LO +: CLUSTERS] : '0;
        end
      end
    end
  end

  // read side, answer one cycle after the address is taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= cell_chain_pkg::RESP_OKAY;
    end else if (ce) begin
      if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
      if (ar_hs) begin
        rvalid_r <= 1'b1;
        rresp_r <= cell_chain_pkg::RESP_OKAY;
        rdata_r <= 32'h0000_0000;
        if (s_axi_araddr == cell_chain_pkg::OFF_CTRL) begin
          rdata_r <= 32'(ctrl_r);
        end else if (s_axi_araddr == cell_chain_pkg::OFF_LUT) begin
          rdata_r <= 32'(lut_r);
        end else if (s_axi_araddr == cell_chain_pkg::OFF_OP1) begin
          rdata_r <= 32'(op1_r);
        end else if (s_axi_araddr == cell_chain_pkg::OFF_OP2) begin
          rdata_r <= 32'(op2_r);
        end else if (s_axi_araddr == cell_chain_pkg::OFF_OP3) begin
          rdata_r <= 32'(op3_r);
        end else if (s_axi_araddr == cell_chain_pkg::OFF_OP4) begin
          rdata_r <= 32'(op4_r);
        end else if (s_axi_araddr == cell_chain_pkg::OFF_LOADVAL) begin
          rdata_r <= 32'(loadval_r);
        end else if (s_axi_araddr == cell_chain_pkg::OFF_CMD) begin
          rdata_r <= 32'h0000_0000;
        end else if (s_axi_araddr == cell_chain_pkg::OFF_OUTA) begin
          rdata_r <= 32'(out_a_w);
        end else if (s_axi_araddr == cell_chain_pkg::OFF_OUTB) begin
          rdata_r <= 32'(out_b_w);
        end else if (s_axi_araddr == cell_chain_pkg::OFF_STATUS) begin
          rdata_r <= {30'h00000000, cs_w[NCELL], cy_w[NCELL]};
        end else if (s_axi_araddr == cell_chain_pkg::OFF_REGQ) begin
          rdata_r <= 32'(q_r);
        end else begin
          rresp_r <= cell_chain_pkg::RESP_SLVERR;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks; prot inputs carry nothing this block uses
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [NCELL-1:0] add_ref;
  logic quiet;
  assign add_ref = NCELL'({1'b0, op1_r[NCELL-2:0]}) + NCELL'({1'b0, op2_r[NCELL-2:0]})
                   + NCELL'(cy_w[0]);
  assign quiet = ce && cell_ce && !(|clr_r) && !(|load_r);

  sequence s_wr_taken;
    aw_hs && w_hs;
  endsequence
  sequence s_resp;
    ##1 bvalid_r;
  endsequence

  property p_adder;
    (mode == cell_chain_pkg::MODE_ARITH && lut_r == cell_chain_pkg::LUT_RST)
      |-> f_w == add_ref;
  endproperty
  a_adder: assert property (p_adder) else $error("adder sum mismatch");

  property p_cas_and;
    (!cas_or) |-> cs_w[NCELL] == (&f_w);
  endproperty
  a_cas_and: assert property (p_cas_and) else $error("cascade and wrong");

  property p_cas_or;
    (cas_or) |-> cs_w[NCELL] == (|f_w);
  endproperty
  a_cas_or: assert property (p_cas_or) else $error("cascade or wrong");

  property p_clear;
    (ce && cell_ce && (&clr_r)) |=> q_r == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not win");

  property p_load;
    (ce && cell_ce && !(|clr_r) && (&load_r)) |=> q_r == $past(loadval_r);
  endproperty
  a_load: assert property (p_load) else $error("load not taken");

  property p_hold;
    (!ce || !cell_ce) |=> $stable(q_r);
  endproperty
  a_hold: assert property (p_hold) else $error("register moved while disabled");

  property p_count_up;
    (quiet && mode == cell_chain_pkg::MODE_COUNTER && (&op1_r) && (&op2_r) && cy_w[0])
      |=> q_r == NCELL'($past(q_r) + 1'b1);
  endproperty
  a_count_up: assert property (p_count_up) else $error("count step wrong");

  property p_packed;
    (quiet && mode == cell_chain_pkg::MODE_NORMAL) |=> q_r == $past(op4_r);
  endproperty
  a_packed: assert property (p_packed) else $error("packed register wrong");

  property p_wr_resp;
    s_wr_taken |-> s_resp;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response missing");

endmodule // logic_cell_carry_cascade

// ===== verification/axil_master.sv
`timescale 1ns/1ps
module axil_master (
  input wire logic clk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // handshakes judged at the falling edge, so no race with the rising edge
  task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb) begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid & bready;
      resp = bresp;
      @(posedge clk);
      // released payload shows a changed value, not the old one
      if (ta) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (tw) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (tb) bready <= 1'b0;
    end
  endtask
  task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ta, tr;
    tr = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr) begin
      @(negedge clk);
      ta = arvalid & arready;
      tr = rvalid & rready;
      d = rdata;
      resp = rresp;
      @(posedge clk);
      if (ta) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (tr) rready <= 1'b0;
    end
  endtask
endmodule // axil_master

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam logic [31:0] M30 = 32'h3FFF_FFFF;
  localparam logic [1:0] OK = cell_chain_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = cell_chain_pkg::RESP_SLVERR;
  logic clk, arst_n, ce;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  int errors = 0;
  int total_checks = 0;
  logic [31:0] o1, o2, o3, o4, ld;
  logic [15:0] lut;
  logic [7:0] ctl;
  logic [29:0] e;
  always #5 clk = ~clk;
  logic_cell_carry_cascade i_dut (.clk(clk), .arst_n(arst_n), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  axil_master i_master (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [29:0] norm_out(input logic [15:0] t, input logic [31:0] a, b, c, d,
                                           input logic sel, cin);
    logic [3:0] ix;
    for (int p = 0; p < 30; p++) begin
      ix = {d[p], sel ? cin : c[p], b[p], a[p]};
      norm_out[p] = t[ix];
    end
  endfunction
  function automatic logic [29:0] add_out(input logic [31:0] a, b, input logic c);
    add_out = {1'b0, a[28:0]} + {1'b0, b[28:0]} + {29'h0, c};
  endfunction
  task automatic chk(input logic [31:0] got, exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    i_master.write(a, d, r);
    chk({30'h0, r}, {30'h0, er}, "bresp");
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, m, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    i_master.read(a, d, r);
    chk(d & m, ex & m, "rdata");
    chk({30'h0, r}, {30'h0, er}, "rresp");
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    errors++;
    results();
  end
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    ce = 1'b1;
    void'($urandom(73295));
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(cell_chain_pkg::OFF_CTRL, 32'h60, 32'hFF, OK);
    wr(cell_chain_pkg::OFF_LUT + 8'h01, 32'h0, ERR);
    wr(cell_chain_pkg::OFF_OUTA, 32'hFFFF_FFFF, ERR);
    rd(cell_chain_pkg::OFF_LUT, 32'hE896, 32'hFFFF, OK);
    rd(8'h30, 32'h0, 32'hFFFF_FFFF, ERR);
    // normal mode: random tables, in3 source, cascade kind, out_a source
    for (int i = 0; i < 8; i++) begin
      lut = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($urandom);
      ctl = 8'h60 | 8'($urandom & 32'h9C);
      o1 = $urandom & M30;
      o2 = $urandom & M30;
      o3 = $urandom & M30;
      o4 = $urandom & M30;
      wr(cell_chain_pkg::OFF_CTRL, {24'h0, ctl}, OK);
      wr(cell_chain_pkg::OFF_LUT, {16'h0, lut}, OK);
      wr(cell_chain_pkg::OFF_OP1, o1, OK);
      wr(cell_chain_pkg::OFF_OP2, o2, OK);
      wr(cell_chain_pkg::OFF_OP3, o3, OK);
      wr(cell_chain_pkg::OFF_OP4, o4, OK);
      e = norm_out(lut, o1, o2, o3, o4, ctl[3], ctl[7]);
      rd(cell_chain_pkg::OFF_OUTA, ctl[4] ? o4 : {2'b0, e}, M30, OK);
      rd(cell_chain_pkg::OFF_REGQ, o4, M30, OK);
      rd(cell_chain_pkg::OFF_OUTB, o4, M30, OK);
      rd(cell_chain_pkg::OFF_STATUS, {30'h0, ctl[2] ? |e : &e, ctl[7]}, 32'h3, OK);
    end
    // arithmetic: 29-bit adder across all three clusters, first case ripples all the way
    wr(cell_chain_pkg::OFF_LUT, 32'hE896, OK);
    for (int i = 0; i < 6; i++) begin
      o1 = (i == 0) ? 32'h1FFF_FFFF : $urandom;
      o2 = (i == 0) ? 32'h0 : $urandom;
      ctl = (i == 0) ? 8'hE1 : (8'h61 | 8'($urandom & 32'h80));
      wr(cell_chain_pkg::OFF_CTRL, {24'h0, ctl}, OK);
      wr(cell_chain_pkg::OFF_OP1, o1, OK);
      wr(cell_chain_pkg::OFF_OP2, o2, OK);
      e = add_out(o1, o2, ctl[7]);
      rd(cell_chain_pkg::OFF_OUTA, {2'b0, e}, M30, OK);
      rd(cell_chain_pkg::OFF_OUTB, {2'b0, e}, 32'h1FFF_FFFF, OK);
    end
    // counter: whole clusters serve one counter, count enable off so loads stay put
    wr(cell_chain_pkg::OFF_CTRL, 32'h62, OK);
    wr(cell_chain_pkg::OFF_OP1, 32'h0, OK);
    ld = $urandom & M30;
    wr(cell_chain_pkg::OFF_LOADVAL, ld, OK);
    wr(cell_chain_pkg::OFF_CMD, 32'h700, OK);
    rd(cell_chain_pkg::OFF_REGQ, ld, M30, OK);
    wr(cell_chain_pkg::OFF_CMD, 32'h002, OK);
    rd(cell_chain_pkg::OFF_REGQ, ld & ~32'h3FF0_0000, M30, OK);
    wr(cell_chain_pkg::OFF_CMD, 32'h101, OK);
    rd(cell_chain_pkg::OFF_OUTB, ld & 32'h000F_FC00, M30, OK);
    wr(cell_chain_pkg::OFF_CTRL, 32'h22, OK);
    wr(cell_chain_pkg::OFF_CMD, 32'h700, OK);
    rd(cell_chain_pkg::OFF_REGQ, ld & 32'h000F_FC00, M30, OK);
    rd(cell_chain_pkg::OFF_CMD, 32'h0, 32'hFFFF_FFFF, OK);
    // clear on every cluster beats a load on every cluster
    wr(cell_chain_pkg::OFF_CTRL, 32'h62, OK);
    wr(cell_chain_pkg::OFF_CMD, 32'h707, OK);
    rd(cell_chain_pkg::OFF_REGQ, 32'h0, M30, OK);
    // seed off keeps the counter still while operands change
    wr(cell_chain_pkg::OFF_CMD, 32'h700, OK);
    wr(cell_chain_pkg::OFF_OP2, M30, OK);
    wr(cell_chain_pkg::OFF_OP1, M30, OK);
    // counts on the edge after the write, then frozen, then two edges around the stop write
    wr(cell_chain_pkg::OFF_CTRL, 32'hE2, OK);
    ce <= 1'b0;
    repeat (5) @(posedge clk);
    chk({31'h0, awready}, 32'h0, "ready while frozen");
    ce <= 1'b1;
    wr(cell_chain_pkg::OFF_CTRL, 32'h62, OK);
    rd(cell_chain_pkg::OFF_REGQ, (ld + 32'h3) & M30, M30, OK);
    // same three edges counting down, no freeze
    wr(cell_chain_pkg::OFF_OP2, 32'h0, OK);
    wr(cell_chain_pkg::OFF_CTRL, 32'hE2, OK);
    wr(cell_chain_pkg::OFF_CTRL, 32'h62, OK);
    rd(cell_chain_pkg::OFF_REGQ, ld, M30, OK);
    results();
  end
endmodule // testbench
